//--- hw/dbc_pkg.sv
// Purpose: shared constants for the boot check and soft-reset sequencer
// Assumes: 100 MHz core clock
// Notes:   times are kept in their own unit, cycle counts derive from them
package dbc_pkg;
   localparam int unsigned CLK_MHZ        = 100;
   localparam int unsigned INIT_TIME_US   = 5000;
   localparam int unsigned INIT_CYCLES    = INIT_TIME_US * CLK_MHZ;
   localparam int unsigned TIMER_W        = 20;
   localparam logic [23:0] MSG_RESTART    = 24'h000001;
   localparam logic [23:0] MSG_PLL_LOCK   = 24'h000002;
   localparam logic [7:0]  BYTE_APP_FAIL  = 8'hf0;
   localparam logic [7:0]  BYTE_LOAD_OK   = 8'h00;
   localparam logic [2:0]  MODE_RST       = 3'h0;
   localparam int unsigned MODE_WR_POS    = 0;
   localparam int unsigned MODE_RD_POS    = 1;
   localparam int unsigned MODE_PSEL_POS  = 2;
   typedef enum logic [4:0] {
      DBC_HOLD  = 5'h01,
      DBC_LOAD  = 5'h02,
      DBC_INIT  = 5'h04,
      DBC_READY = 5'h08,
      DBC_FAIL  = 5'h10
   } dbc_state_e;
endpackage

//--- hw/dbc_timer_if.sv
// Purpose: start, abort and done signals between sequencer and init timer
// Assumes: both ends on clock_i
// Notes:   start is a one-cycle pulse, done a one-cycle pulse
`timescale 1ns/10ps
`default_nettype none
interface dbc_timer_if;
   logic start;
   logic abort;
   logic done;
   modport ctl (output start, output abort, input done);
   modport tmr (input start, input abort, output done);
endinterface
`default_nettype wire

//--- hw/dbc_init_timer.sv
// Purpose: counts the application initialisation interval
// Assumes: start and abort never in the same cycle as meaningful done
// Notes:   a new start restarts the count
`timescale 1ns/10ps
`default_nettype none
module dbc_init_timer #(
   parameter int unsigned CYCLES = dbc_pkg::INIT_CYCLES
) (
   // clock and reset
   input  wire logic clock_i,
   input  wire logic arst_n_i,
   // control
   dbc_timer_if.tmr  tif
);
   logic [dbc_pkg::TIMER_W-1:0] count;
   logic                        running;

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         count   <= '0;
         running <= 1'b0;
         tif.done <= 1'b0;
      end else begin
         tif.done <= 1'b0;
         if (tif.abort) begin
            running <= 1'b0;
         end else if (tif.start) begin
            count   <= dbc_pkg::TIMER_W'(CYCLES - 1);
            running <= 1'b1;
         end else if (running) begin
            if (count == '0) begin
               running  <= 1'b0;
               tif.done <= 1'b1;
            end else begin
               count <= count - 1'b1;
            end
         end
      end
   end
endmodule
`default_nettype wire

//--- hw/dbc_boot_check.sv
// Purpose: device-side boot completion check and soft-reset sequencing
// Assumes: message decoder and loader on clock_i; reset and mode pins asynchronous
// Notes:   shared request pin is open-drain, oe_n low while pulling low
//
// Functional notes
// - fast helper running keeps PLL unlocked
// - PLL locks only on host lock command
// - loaded assist enables matching internal application
// - wrong-family image never finishes initialisation
// - request low after failed load; byte f0 fail
// - failure report for host and self load
// - restart message reruns application at defaults
// - mode pins captured on reset rising edge
// - shared pin input before, output after reset
`timescale 1ns/10ps
`default_nettype none
module dbc_boot_check #(
   parameter int unsigned INIT_CYCLES = dbc_pkg::INIT_CYCLES
) (
   // clock and reset
   input  wire logic        clock_i,
   input  wire logic        arst_n_i,
   // pins from host
   input  wire logic        pin_reset_n_i,
   input  wire logic        pin_wr_i,
   input  wire logic        pin_rd_i,
   input  wire logic        pin_psel_i,
   input  wire logic        self_load_select_i,
   output logic             host_interrupt_request_o,
   output logic             host_interrupt_request_oe_n_o,
   // loader side
   input  wire logic        load_done_i,
   input  wire logic        load_family_ok_i,
   input  wire logic        load_is_assist_i,
   input  wire logic        fast_helper_run_i,
   // decoded messages and reads
   input  wire logic        msg_valid_i,
   input  wire logic [23:0] msg_code_i,
   input  wire logic        byte_read_i,
   output logic [7:0]       byte_data_o,
   output logic             byte_valid_o,
   // core control
   output logic [2:0]       comm_mode_o,
   output logic             self_load_o,
   output logic             pll_lock_o,
   output logic             rom_app_enable_o,
   output logic             app_restart_o,
   output logic             app_ready_o,
   output logic             app_failed_o
);
   // ****************************************
   // pin synchronisers
   // ****************************************
   logic [4:0] sync1;
   logic [4:0] sync2;
   logic       rst_pin_q;
   dbc_pkg::dbc_state_e state;
   dbc_pkg::dbc_state_e next_state;
   logic       downloaded;
   dbc_timer_if tif ();

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sync1 <= 5'h00;
         sync2 <= 5'h00;
      end else begin
         sync1 <= {self_load_select_i, pin_psel_i, pin_rd_i, pin_wr_i, pin_reset_n_i};
         sync2 <= sync1;
      end
   end

   wire rst_pin  = sync2[0];
   wire rst_rise = rst_pin & ~rst_pin_q;
   wire msg_restart = msg_valid_i && msg_code_i == dbc_pkg::MSG_RESTART;
   wire msg_lock    = msg_valid_i && msg_code_i == dbc_pkg::MSG_PLL_LOCK;

   // ****************************************
   // strap capture
   // ****************************************
   // straps are sampled at the synced release, never inside the async reset
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rst_pin_q   <= 1'b0;
         comm_mode_o <= dbc_pkg::MODE_RST;
         self_load_o <= 1'b0;
      end else begin
         rst_pin_q <= rst_pin;
         if (rst_rise) begin
            comm_mode_o <= sync2[3:1];
            self_load_o <= sync2[4];
         end
      end
   end

   // ****************************************
   // sequencer
   // ****************************************
   always_comb begin
      next_state = state;
      case (state)
         dbc_pkg::DBC_HOLD:  if (rst_rise) next_state = dbc_pkg::DBC_LOAD;
         dbc_pkg::DBC_LOAD: begin
            if (msg_restart && downloaded) begin
               next_state = dbc_pkg::DBC_INIT;
            end else if (load_done_i) begin
               // mismatched image still loads but never initialises
               next_state = load_family_ok_i ? dbc_pkg::DBC_INIT
                                             : dbc_pkg::DBC_FAIL;
            end
         end
         dbc_pkg::DBC_INIT:  if (tif.done) next_state = dbc_pkg::DBC_READY;
         dbc_pkg::DBC_READY: next_state = dbc_pkg::DBC_READY;
         dbc_pkg::DBC_FAIL:  next_state = dbc_pkg::DBC_FAIL;
         default:            next_state = dbc_pkg::DBC_HOLD;
      endcase
      if (!rst_pin) begin
         next_state = dbc_pkg::DBC_HOLD;
      end
   end

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state <= dbc_pkg::DBC_HOLD;
      end else begin
         state <= next_state;
      end
   end

   assign tif.start = (state == dbc_pkg::DBC_LOAD) && (next_state == dbc_pkg::DBC_INIT);
   assign tif.abort = !rst_pin;

   dbc_init_timer #(
      .CYCLES (INIT_CYCLES)
   ) u_timer (
      .clock_i  (clock_i),
      .arst_n_i (arst_n_i),
      .tif      (tif)
   );

   // ****************************************
   // application state
   // ****************************************
   // an image survives a pin reset so a restart message can rerun it
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         downloaded       <= 1'b0;
         rom_app_enable_o <= 1'b0;
         app_restart_o    <= 1'b0;
         app_ready_o      <= 1'b0;
         app_failed_o     <= 1'b0;
      end else begin
         app_restart_o <= tif.start && msg_restart;
         app_ready_o   <= (next_state == dbc_pkg::DBC_READY);
         app_failed_o  <= (next_state == dbc_pkg::DBC_FAIL);
         if (state == dbc_pkg::DBC_LOAD && load_done_i && !msg_restart) begin
            downloaded       <= load_family_ok_i;
            rom_app_enable_o <= load_is_assist_i && load_family_ok_i;
         end
      end
   end

   // ****************************************
   // pll lock
   // ****************************************
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pll_lock_o <= 1'b0;
      end else if (!rst_pin || fast_helper_run_i) begin
         pll_lock_o <= 1'b0;
      end else if (msg_lock) begin
         pll_lock_o <= 1'b1;
      end
   end

   // ****************************************
   // shared request pin and status byte
   // ****************************************
   // pin is released until the reset pin rises, then pulls low on failure only
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         host_interrupt_request_o      <= 1'b0;
         host_interrupt_request_oe_n_o <= 1'b1;
         byte_data_o                   <= 8'h00;
         byte_valid_o                  <= 1'b0;
      end else begin
         host_interrupt_request_o      <= 1'b0;
         host_interrupt_request_oe_n_o <= !(rst_pin && next_state == dbc_pkg::DBC_FAIL);
         byte_valid_o                  <= byte_read_i;
         if (byte_read_i) begin
            byte_data_o <= (state == dbc_pkg::DBC_FAIL) ? dbc_pkg::BYTE_APP_FAIL
                                                         : dbc_pkg::BYTE_LOAD_OK;
         end
      end
   end

   // ****************************************
   // checks
   // ****************************************
   sequence s_bad_load;
      state == dbc_pkg::DBC_LOAD && rst_pin && load_done_i && !load_family_ok_i && !msg_restart;
   endsequence
   sequence s_fail_pin;
      !host_interrupt_request_oe_n_o [*2];
   endsequence

   a_fast_no_lock: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      fast_helper_run_i |=> !pll_lock_o) else $error("pll locked under fast helper");
   a_lock_cause: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      $rose(pll_lock_o) |-> $past(msg_lock)) else $error("pll locked without command");
   // second low cycle only holds while the synced reset pin is still high
   a_fail_pulls: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      s_bad_load ##1 rst_pin |-> s_fail_pin) else $error("fail not signalled");
   a_fail_byte: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      byte_read_i && state == dbc_pkg::DBC_FAIL
      |=> byte_valid_o && byte_data_o == dbc_pkg::BYTE_APP_FAIL)
      else $error("wrong failure byte");
   a_no_ready_bad: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      s_bad_load |=> !app_ready_o [*4]) else $error("bad image became ready");
   a_pin_input: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      !rst_pin |=> host_interrupt_request_oe_n_o) else $error("pin driven in reset");
   a_mode_latch: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      rst_rise |=> comm_mode_o == $past(sync2[3:1])) else $error("mode not captured");
   a_mode_hold: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      !rst_rise |=> $stable(comm_mode_o)) else $error("mode changed without reset edge");
   a_restart_run: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      state == dbc_pkg::DBC_LOAD && rst_pin && msg_restart && downloaded
      |=> app_restart_o && state == dbc_pkg::DBC_INIT) else $error("restart ignored");
   a_assist_enable: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      state == dbc_pkg::DBC_LOAD && rst_pin && load_done_i && load_is_assist_i
      && load_family_ok_i && !msg_restart |=> rom_app_enable_o)
      else $error("rom app not enabled");
endmodule
`default_nettype wire

//--- bench/dbc_host_model.sv
// Purpose: host partner driving reset, mode pins, strap and messages
// Assumes: shared strap pin has a pull-up
// Notes:   reset low time is an argument, so slow parts fit
`timescale 1ns/10ps
`default_nettype none
module dbc_host_model (
   // clock
   input  wire logic   clock_i,
   // pins to device
   output logic        pin_reset_n_o,
   output logic [2:0]  mode_o,
   output logic        strap_o,
   input  wire logic   irq_oe_n_i,
   // decoded traffic
   output logic        msg_valid_o,
   output logic [23:0] msg_code_o,
   output logic        byte_read_o
);
   logic host_pull_n;
   // open-drain wire: either party may pull it low
   assign strap_o = host_pull_n & irq_oe_n_i;
   initial begin
      pin_reset_n_o = 1'b1;
      mode_o = 3'h0;
      host_pull_n = 1'b1;
      msg_valid_o = 1'b0;
      msg_code_o = 24'h0;
      byte_read_o = 1'b0;
   end
   // mode pins held across the rising edge, strap let go after it
   task automatic hard_reset(input logic [2:0] mode, input logic strap, input int low_cyc);
      @(posedge clock_i);
      pin_reset_n_o <= 1'b0;
      mode_o <= mode;
      host_pull_n <= strap;
      repeat (low_cyc) @(posedge clock_i);
      pin_reset_n_o <= 1'b1;
      repeat (6) @(posedge clock_i);
      host_pull_n <= 1'b1;
   endtask
   // code lines flip once released so a stale value is never seen
   task automatic send_msg(input logic [23:0] code);
      @(posedge clock_i);
      msg_valid_o <= 1'b1;
      msg_code_o <= code;
      @(posedge clock_i);
      msg_valid_o <= 1'b0;
      msg_code_o <= ~code;
   endtask
   // only used once a load is over, the request pin is ignored before
   task automatic read_byte();
      @(posedge clock_i);
      byte_read_o <= 1'b1;
      @(posedge clock_i);
      byte_read_o <= 1'b0;
   endtask
endmodule
`default_nettype wire

//--- bench/dsp_boot_check_and_soft_reset_tb.sv
// Purpose: self-checking bench for the boot check and soft-reset sequencer
// Assumes: init interval shortened to INIT cycles
// Notes:   expectations come from a small model of ints and a queue
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin miscompares++; \
   $display("unexpected %s expected %h seen %h", nm, ex, got); end end
module dsp_boot_check_and_soft_reset_tb;
   localparam int INIT = 20;
   logic        clock, arst_n, load_done, family_ok, is_assist, fast_run;
   logic        pin_reset_n, strap, msg_valid, byte_read, irq, irq_oe_n;
   logic        byte_valid, self_load, pll, rom_en, restart, ready, failed;
   logic [2:0]  mode, comm_mode;
   logic [23:0] msg_code;
   logic [7:0]  byte_data, exp_b;
   logic [31:0] rng = 32'h73ca;
   int          miscompares = 0, tests_run = 0, n, r, rom_exp = 0;
   logic [7:0]  byte_q[$];
   dbc_host_model host (.clock_i(clock), .pin_reset_n_o(pin_reset_n), .mode_o(mode),
      .strap_o(strap), .irq_oe_n_i(irq_oe_n), .msg_valid_o(msg_valid),
      .msg_code_o(msg_code), .byte_read_o(byte_read));
   dbc_boot_check #(.INIT_CYCLES(INIT)) uut (.clock_i(clock), .arst_n_i(arst_n),
      .pin_reset_n_i(pin_reset_n), .pin_wr_i(mode[0]), .pin_rd_i(mode[1]),
      .pin_psel_i(mode[2]), .self_load_select_i(strap), .host_interrupt_request_o(irq),
      .host_interrupt_request_oe_n_o(irq_oe_n), .load_done_i(load_done),
      .load_family_ok_i(family_ok), .load_is_assist_i(is_assist),
      .fast_helper_run_i(fast_run), .msg_valid_i(msg_valid), .msg_code_i(msg_code),
      .byte_read_i(byte_read), .byte_data_o(byte_data), .byte_valid_o(byte_valid),
      .comm_mode_o(comm_mode), .self_load_o(self_load), .pll_lock_o(pll),
      .rom_app_enable_o(rom_en), .app_restart_o(restart), .app_ready_o(ready),
      .app_failed_o(failed));
   // ****************
   // helpers
   // ****************
   always #5 clock = ~clock;
   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] t;
      t = v ^ (v << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   task automatic finish_test();
      if (miscompares == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // counts restart pulses until ready, bounded by lim
   task automatic watch(input int lim, input bit need);
      n = 0;
      r = 0;
      while (n < lim && ready !== 1'b1) begin
         @(negedge clock);
         n++;
         if (restart === 1'b1) r++;
      end
      if (need && ready !== 1'b1) begin
         miscompares++;
         finish_test();
      end
   endtask
   task automatic load(input logic fam, input logic assist);
      @(posedge clock);
      load_done <= 1'b1;
      family_ok <= fam;
      is_assist <= assist;
      @(posedge clock);
      load_done <= 1'b0;
   endtask
   task automatic check_byte();
      host.read_byte();
      n = 0;
      while (n < 4 && byte_valid !== 1'b1) begin
         @(negedge clock);
         n++;
      end
      if (byte_valid !== 1'b1) begin
         miscompares++;
         finish_test();
      end
      exp_b = byte_q.pop_front();
      `CHK("status byte", exp_b, byte_data)
   endtask
   // ****************
   // main sequence
   // ****************
   initial begin
      clock = 1'b0;
      arst_n = 1'b0;
      load_done = 1'b0;
      family_ok = 1'b0;
      is_assist = 1'b0;
      fast_run = 1'b0;
      repeat (8) @(posedge clock);
      arst_n <= 1'b1;
      @(negedge clock);
      `CHK("oe_n after reset", 1'b1, irq_oe_n)
      `CHK("pll after reset", 1'b0, pll)
      host.hard_reset(3'h0, 1'b1, 4);
      host.send_msg(dbc_pkg::MSG_RESTART);
      watch(8, 1'b0);
      `CHK("restart with nothing loaded", 0, r)
      for (int k = 0; k < 4; k++) begin
         rng = xs(rng);
         host.hard_reset(rng[2:0], k[0], 4);
         @(negedge clock);
         `CHK("mode capture", rng[2:0], comm_mode)
         `CHK("strap capture", k[0], self_load)
         `CHK("pin released", 1'b1, irq_oe_n)
         load(k[1], k[0]);
         rom_exp = rom_exp | (k[1] & k[0]);
         byte_q.push_back(k[1] ? dbc_pkg::BYTE_LOAD_OK : dbc_pkg::BYTE_APP_FAIL);
         if (k[1]) begin
            watch(INIT + 10, 1'b1);
            `CHK("ready delay", 1'b1, (n >= INIT && n <= INIT + 4))
         end else begin
            repeat (3) @(negedge clock);
         end
         `CHK("failed flag", ~k[1], failed)
         `CHK("request pin enable", k[1], irq_oe_n)
         `CHK("request pin value", 1'b0, irq)
         `CHK("rom application", rom_exp[0], rom_en)
         check_byte();
         if (k[1]) begin
            @(posedge clock);
            // helper is started at a divider the memory can follow
            fast_run <= 1'b1;
            host.send_msg(dbc_pkg::MSG_PLL_LOCK);
            repeat (2) @(negedge clock);
            `CHK("lock while helper runs", 1'b0, pll)
            @(posedge clock);
            fast_run <= 1'b0;
            host.send_msg(dbc_pkg::MSG_PLL_LOCK);
            repeat (2) @(negedge clock);
            `CHK("lock on command", 1'b1, pll)
            @(posedge clock);
            fast_run <= 1'b1;
            repeat (2) @(negedge clock);
            `CHK("unlock when helper runs", 1'b0, pll)
            @(posedge clock);
            fast_run <= 1'b0;
            // soft reset, only once something is resident
            host.hard_reset(rng[2:0], 1'b1, 4);
            @(negedge clock);
            `CHK("pll after hard reset", 1'b0, pll)
            host.send_msg(dbc_pkg::MSG_RESTART);
            watch(INIT + 10, 1'b1);
            `CHK("restart pulse", 1, r)
            `CHK("rom kept", rom_exp[0], rom_en)
         end
      end
      finish_test();
   end
endmodule
`default_nettype wire
